// ---- acg_dev.sv ----
// calibration and gpio register bank reached over a spi mode 1 link
`timescale 1ns/1ps
`include "acg_cfg.svh"

module acg_dev #(
    parameter bit SIX_CHAN = 1'b0
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // spi link
    acg_spi_if.dev           link,
    // calibration values
    output logic [15:0]      offset_cal_value_out,
    output logic [15:0]      gain_cal_value_out,
    // gpio pins
    input  wire logic [3:0]  gpio_in,
    output logic [3:0]       gpio_out,
    output logic [3:0]       gpio_oe_out
);
    import acg_pkg::*;

    acg_pkg::acg_dev_st_t st_ff;
    acg_pkg::acg_dev_st_t nxt_st;

    logic       sclk_new;
    logic       cs_new;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] rx_full;
    logic [4:0] addr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a change counts only once stages two and three agree
    function automatic logic flt(input logic [2:0] s, input logic old);
        flt = (s[1] == s[2]) ? s[2] : old;
    endfunction

    function automatic logic [7:0] rd_reg(input acg_pkg::acg_dev_st_t s,
                                          input logic [4:0] a);
        logic [3:0] lvl;
        lvl    = `ACG_NIB_ZERO;
        rd_reg = `ACG_RST_ZERO;
        for (int i = 0; i < 4; i++) begin
            if (s.gpio_fs[i] && s.gpio_ld[`ACG_DIR_LO + i]) begin
                lvl[i] = s.gpio_f[i];
            end else if (SIX_CHAN && !s.gpio_fs[i]) begin
                lvl[i] = 1'b0;
            end else begin
                lvl[i] = s.gpio_ld[`ACG_LVL_LO + i];
            end
        end
        case (a)
            `ACG_ADDR_OFS_LO:  rd_reg = s.ofs_lo;
            `ACG_ADDR_OFS_HI:  rd_reg = s.ofs_hi;
            `ACG_ADDR_RSVD:    rd_reg = `ACG_RST_ZERO;
            `ACG_ADDR_GAIN_LO: rd_reg = s.gain_lo;
            `ACG_ADDR_GAIN_HI: rd_reg = s.gain_hi;
            `ACG_ADDR_GPIO_LD: rd_reg = {s.gpio_ld[`ACG_DIR_HI:`ACG_DIR_LO], lvl};
            `ACG_ADDR_GPIO_FS: rd_reg = {`ACG_NIB_ZERO, s.gpio_fs[`ACG_LVL_HI:0]};
            default:           rd_reg = `ACG_RST_ZERO;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // input synchronisers, first stage feeds only the second
        nxt_st.sclk_s = {st_ff.sclk_s[1:0], link.sclk};
        nxt_st.cs_s   = {st_ff.cs_s[1:0], link.cs_n};
        nxt_st.mosi_s = {st_ff.mosi_s[1:0], link.mosi};
        for (int i = 0; i < 4; i++) begin
            nxt_st.gpio_s[i] = {st_ff.gpio_s[i][1:0], gpio_in[i]};
            nxt_st.gpio_f[i] = flt(st_ff.gpio_s[i], st_ff.gpio_f[i]);
        end

        sclk_new      = flt(st_ff.sclk_s, st_ff.sclk_f);
        cs_new        = flt(st_ff.cs_s, st_ff.cs_f);
        nxt_st.sclk_f = sclk_new;
        nxt_st.cs_f   = cs_new;
        nxt_st.mosi_f = flt(st_ff.mosi_s, st_ff.mosi_f);

        // mode 1: clock idles low, launch on rise, sample on fall
        sclk_rise = sclk_new && !st_ff.sclk_f;
        sclk_fall = !sclk_new && st_ff.sclk_f;
        rx_full   = {st_ff.rx[6:0], st_ff.mosi_f};
        addr      = st_ff.cmd[`ACG_ADDR_HI:0];

        if (cs_new) begin
            // deselected: frame aborted, output parked low
            nxt_st.st      = ACG_DEV_IDLE;
            nxt_st.bit_cnt = `ACG_NIB_ZERO;
            nxt_st.miso    = 1'b0;
        end else begin
            case (st_ff.st)
                ACG_DEV_IDLE: begin
                    nxt_st.st      = ACG_DEV_CMD;
                    nxt_st.bit_cnt = `ACG_NIB_ZERO;
                    nxt_st.miso    = 1'b0;
                end
                ACG_DEV_CMD: begin
                    if (sclk_rise) begin
                        nxt_st.miso = 1'b0;
                    end
                    if (sclk_fall) begin
                        nxt_st.rx      = rx_full;
                        nxt_st.bit_cnt = st_ff.bit_cnt + `ACG_BIT_ONE;
                        if (st_ff.bit_cnt == `ACG_CMD_LAST) begin
                            nxt_st.cmd = rx_full;
                            nxt_st.tx  = rd_reg(st_ff, rx_full[`ACG_ADDR_HI:0]);
                            nxt_st.st  = ACG_DEV_DATA;
                        end
                    end
                end
                ACG_DEV_DATA: begin
                    if (sclk_rise) begin
                        nxt_st.miso = st_ff.tx[7];
                        nxt_st.tx   = {st_ff.tx[6:0], 1'b0};
                    end
                    if (sclk_fall) begin
                        nxt_st.rx      = rx_full;
                        nxt_st.bit_cnt = st_ff.bit_cnt + `ACG_BIT_ONE;
                        if (st_ff.bit_cnt == `ACG_FRAME_LAST) begin
                            nxt_st.st = ACG_DEV_DONE;
                            if (st_ff.cmd[`ACG_CMD_WR_BIT]) begin
                                case (addr)
                                    `ACG_ADDR_OFS_LO:  nxt_st.ofs_lo  = rx_full;
                                    `ACG_ADDR_OFS_HI:  nxt_st.ofs_hi  = rx_full;
                                    `ACG_ADDR_GAIN_LO: nxt_st.gain_lo = rx_full;
                                    `ACG_ADDR_GAIN_HI: nxt_st.gain_hi = rx_full;
                                    `ACG_ADDR_GPIO_LD: nxt_st.gpio_ld = rx_full;
                                    `ACG_ADDR_GPIO_FS: begin
                                        // upper nibble is read only
                                        nxt_st.gpio_fs = {`ACG_NIB_ZERO,
                                                          rx_full[`ACG_LVL_HI:0]};
                                    end
                                    default: begin
                                        // reserved and unmapped writes dropped
                                        nxt_st.gpio_fs = st_ff.gpio_fs;
                                    end
                                endcase
                            end
                        end
                    end
                end
                ACG_DEV_DONE: begin
                    // extra clocks after a full frame shift nothing
                    if (sclk_rise) begin
                        nxt_st.miso = 1'b0;
                    end
                end
                default: begin
                    nxt_st.st = ACG_DEV_IDLE;
                end
            endcase
        end

        if (!reset_n_in) begin
            nxt_st         = '0;
            nxt_st.st      = ACG_DEV_IDLE;
            nxt_st.cs_s    = 3'h7;
            nxt_st.cs_f    = 1'b1;
            nxt_st.ofs_lo  = `ACG_RST_ZERO;
            nxt_st.ofs_hi  = `ACG_RST_ZERO;
            nxt_st.gain_lo = `ACG_RST_ZERO;
            nxt_st.gain_hi = `ACG_RST_GAIN_HI;
            nxt_st.gpio_ld = `ACG_RST_ZERO;
            nxt_st.gpio_fs = `ACG_RST_ZERO;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.serial_out_ready_pin = st_ff.miso;
    assign offset_cal_value_out      = {st_ff.ofs_hi, st_ff.ofs_lo};
    assign gain_cal_value_out        = {st_ff.gain_hi, st_ff.gain_lo};
    assign gpio_out                  = st_ff.gpio_ld[`ACG_LVL_HI:`ACG_LVL_LO];
    // analog pins and inputs never drive
    assign gpio_oe_out = st_ff.gpio_fs[`ACG_LVL_HI:0]
                       & ~st_ff.gpio_ld[`ACG_DIR_HI:`ACG_DIR_LO];

endmodule // acg_dev

// ---- acg_cfg.svh ----
// constants of the calibration and gpio register bank and its spi link
`ifndef ACG_CFG_SVH
`define ACG_CFG_SVH

// ----------------------------------------------------------------
// register addresses of the device
// ----------------------------------------------------------------
`define ACG_ADDR_OFS_LO  5'h0B
`define ACG_ADDR_OFS_HI  5'h0C
`define ACG_ADDR_RSVD    5'h0D
`define ACG_ADDR_GAIN_LO 5'h0E
`define ACG_ADDR_GAIN_HI 5'h0F
`define ACG_ADDR_GPIO_LD 5'h10
`define ACG_ADDR_GPIO_FS 5'h11

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define ACG_RST_ZERO     8'h00
`define ACG_RST_GAIN_HI  8'h40
`define ACG_NIB_ZERO     4'h0
`define ACG_DIR_HI       7
`define ACG_DIR_LO       4
`define ACG_LVL_HI       3
`define ACG_LVL_LO       0

// ----------------------------------------------------------------
// spi frame: command byte then data byte, msb first
// ----------------------------------------------------------------
`define ACG_CMD_WR_BIT   7
`define ACG_ADDR_HI      4
`define ACG_CMD_LAST     4'h7
`define ACG_FRAME_LAST   4'hF
`define ACG_BIT_ONE      4'h1

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
`define ACG_SYS_CLK_NS   8
`define ACG_SCLK_HALF_NS 80
`define ACG_HALF_CYC     ((`ACG_SCLK_HALF_NS + `ACG_SYS_CLK_NS - 1) / `ACG_SYS_CLK_NS)

// ----------------------------------------------------------------
// host wishbone registers and fields
// ----------------------------------------------------------------
`define ACG_WB_CTRL      4'h0
`define ACG_WB_STAT      4'h4
`define ACG_CTRL_START   0
`define ACG_CTRL_WRITE   1
`define ACG_CTRL_ADDR_HI 12
`define ACG_CTRL_ADDR_LO 8
`define ACG_CTRL_DAT_HI  23
`define ACG_CTRL_DAT_LO  16
`define ACG_WORD_ZERO    32'h0000_0000
`define ACG_CNT_ONE      8'h01
`define ACG_CNT_ZERO     8'h00

`endif

// ---- acg_pkg.sv ----
// types shared by both ends of the register bank link
package acg_pkg;

    // ------------------------------------------------------------
    // device frame states, gray along idle-cmd-data-done
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACG_DEV_IDLE = 2'h0,
        ACG_DEV_CMD  = 2'h1,
        ACG_DEV_DATA = 2'h3,
        ACG_DEV_DONE = 2'h2
    } acg_dev_state_t;

    // ------------------------------------------------------------
    // host transfer states, gray along idle-lead-shift-trail
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACG_HST_IDLE  = 2'h0,
        ACG_HST_LEAD  = 2'h1,
        ACG_HST_SHIFT = 2'h3,
        ACG_HST_TRAIL = 2'h2
    } acg_hst_state_t;

    typedef struct packed {
        acg_dev_state_t  st;
        logic [2:0]      sclk_s;
        logic [2:0]      cs_s;
        logic [2:0]      mosi_s;
        logic            sclk_f;
        logic            cs_f;
        logic            mosi_f;
        logic [3:0][2:0] gpio_s;
        logic [3:0]      gpio_f;
        logic [3:0]      bit_cnt;
        logic [7:0]      cmd;
        logic [7:0]      rx;
        logic [7:0]      tx;
        logic            miso;
        logic [7:0]      ofs_lo;
        logic [7:0]      ofs_hi;
        logic [7:0]      gain_lo;
        logic [7:0]      gain_hi;
        logic [7:0]      gpio_ld;
        logic [7:0]      gpio_fs;
    } acg_dev_st_t;

    typedef struct packed {
        acg_hst_state_t  st;
        logic [7:0]      cnt;
        logic [3:0]      bit_cnt;
        logic            sclk;
        logic            cs_n;
        logic            mosi;
        logic [15:0]     tx;
        logic [7:0]      rx;
        logic [2:0]      miso_s;
        logic            miso_f;
        logic            done;
        logic            ack;
        logic [31:0]     dat;
    } acg_hst_st_t;

endpackage

// ---- acg_spi_if.sv ----
// spi mode 1 link between the host controller and the register bank
`timescale 1ns/1ps
interface acg_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic serial_out_ready_pin;

    modport dev (
        input  sclk,
        input  cs_n,
        input  mosi,
        output serial_out_ready_pin
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  serial_out_ready_pin
    );
endinterface

// ---- acg_host.sv ----
// spi mode 1 master that runs one register access per wishbone order
`timescale 1ns/1ps
`include "acg_cfg.svh"

module acg_host (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // wishbone classic slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    // spi link
    acg_spi_if.host          link
);
    import acg_pkg::*;

    localparam logic [7:0] HALF_LAST = 8'(`ACG_HALF_CYC - 1);

    acg_pkg::acg_hst_st_t st_ff;
    acg_pkg::acg_hst_st_t nxt_st;

    logic req;
    logic tick;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.miso_s = {st_ff.miso_s[1:0], link.serial_out_ready_pin};
        nxt_st.miso_f = (st_ff.miso_s[1] == st_ff.miso_s[2]) ? st_ff.miso_s[2]
                                                              : st_ff.miso_f;
        // ------------------------------------------------------------
        // bus slave, ack one cycle after the request
        // ------------------------------------------------------------
        req        = wb_cyc_in && wb_stb_in && !st_ff.ack;
        nxt_st.ack = req;
        if (req && !wb_we_in) begin
            nxt_st.dat = (wb_adr_in == `ACG_WB_STAT)
                       ? {16'h0000, st_ff.rx, 6'h00, st_ff.done,
                          (st_ff.st != ACG_HST_IDLE)}
                       : `ACG_WORD_ZERO;
        end
        // start is ignored while a transfer runs
        if (req && wb_we_in && wb_adr_in == `ACG_WB_CTRL && wb_sel_in[0]
            && wb_dat_in[`ACG_CTRL_START] && st_ff.st == ACG_HST_IDLE) begin
            nxt_st.tx   = {wb_dat_in[`ACG_CTRL_WRITE], 2'h0,
                           wb_dat_in[`ACG_CTRL_ADDR_HI:`ACG_CTRL_ADDR_LO],
                           wb_dat_in[`ACG_CTRL_DAT_HI:`ACG_CTRL_DAT_LO]};
            nxt_st.done = 1'b0;
            nxt_st.cs_n = 1'b0;
            nxt_st.cnt  = `ACG_CNT_ZERO;
            nxt_st.st   = ACG_HST_LEAD;
        end

        // ------------------------------------------------------------
        // clock divider and frame sequencer
        // ------------------------------------------------------------
        tick = (st_ff.cnt == HALF_LAST);
        if (st_ff.st != ACG_HST_IDLE) begin
            nxt_st.cnt = tick ? `ACG_CNT_ZERO : st_ff.cnt + `ACG_CNT_ONE;
        end
        case (st_ff.st)
            ACG_HST_IDLE: begin
                nxt_st.sclk = 1'b0;
            end
            ACG_HST_LEAD: begin
                if (tick) begin
                    nxt_st.bit_cnt = `ACG_NIB_ZERO;
                    nxt_st.st      = ACG_HST_SHIFT;
                end
            end
            ACG_HST_SHIFT: begin
                if (tick && !st_ff.sclk) begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.mosi = st_ff.tx[15];
                    nxt_st.tx   = {st_ff.tx[14:0], 1'b0};
                end else if (tick) begin
                    nxt_st.sclk    = 1'b0;
                    nxt_st.rx      = {st_ff.rx[6:0], st_ff.miso_f};
                    nxt_st.bit_cnt = st_ff.bit_cnt + `ACG_BIT_ONE;
                    if (st_ff.bit_cnt == `ACG_FRAME_LAST) begin
                        nxt_st.st = ACG_HST_TRAIL;
                    end
                end
            end
            ACG_HST_TRAIL: begin
                if (tick) begin
                    nxt_st.cs_n = 1'b1;
                    nxt_st.mosi = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.st   = ACG_HST_IDLE;
                end
            end
            default: begin
                nxt_st.st = ACG_HST_IDLE;
            end
        endcase

        if (!reset_n_in) begin
            nxt_st        = '0;
            nxt_st.st     = ACG_HST_IDLE;
            nxt_st.cs_n   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        st_ff <= nxt_st;
    end

    assign wb_ack_out = st_ff.ack;
    assign wb_dat_out = st_ff.dat;
    assign link.sclk  = st_ff.sclk;
    assign link.cs_n  = st_ff.cs_n;
    assign link.mosi  = st_ff.mosi;

endmodule // acg_host

// ---- acg_link_assertions.sv ----
// concurrent checks on the spi link between host controller and register bank
`timescale 1ns/1ps

module acg_link_check (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // spi link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic serial_out_ready_pin
);
    logic       sclk_q_ff;
    logic [4:0] rise_cnt_ff;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // ------------------------------------------------------------
    // rises seen in the open frame
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        sclk_q_ff <= sclk;
        if (!reset_n_in || cs_n) begin
            rise_cnt_ff <= 5'h00;
        end else if (sclk && !sclk_q_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // wire checks
    // ------------------------------------------------------------
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    a_lead_low: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    a_half_high: assert property ($rose(sclk) |-> sclk [*8])
        else $error("serial clock high phase too short");
    a_mosi_rise_only: assert property ($changed(mosi) && !cs_n && !$past(cs_n)
        |-> $rose(sclk))
        else $error("host data moved away from a rising clock");
    a_miso_rise_only: assert property ($changed(serial_out_ready_pin) && !cs_n
        |-> sclk)
        else $error("device data moved while the clock was low");
    a_mosi_hold_fall: assert property ($rose(sclk) |=> $stable(mosi) [*8])
        else $error("host data unstable before the falling edge");
    a_frame_sixteen: assert property ($rose(cs_n) |-> rise_cnt_ff == 5'h10)
        else $error("frame did not carry sixteen clocks");
    a_trail_wait: assert property ($fell(sclk) && rise_cnt_ff == 5'h10
        |-> !cs_n [*8] ##[1:4] cs_n)
        else $error("select released at the wrong time");

    c_frame_end: cover property ($rose(cs_n));
    c_miso_move: cover property ($changed(serial_out_ready_pin) && !cs_n);
    c_last_fall: cover property ($fell(sclk) && rise_cnt_ff == 5'h10);
endmodule // acg_link_check

// ---- adc_calibration_gpio_registers_bench.sv ----
// self-checking bench for the host controller and register bank pair
`timescale 1ns/1ps
`include "acg_cfg.svh"

module adc_calibration_gpio_registers_bench;
    logic        sys_clk_in;
    logic        reset_n_in;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic        wb_ack;
    logic [3:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic [31:0] wb_rdat_q;
    logic [15:0] ofs_val;
    logic [15:0] gain_val;
    logic [3:0]  pin_ext;
    logic [3:0]  gpio_in;
    logic [3:0]  gpio_out;
    logic [3:0]  gpio_oe;
    logic [7:0]  rd_byte;
    int          err_total;
    int          samples_checked;
    logic [4:0]  addr_tab [7] = '{`ACG_ADDR_OFS_LO, `ACG_ADDR_OFS_HI, `ACG_ADDR_RSVD,
        `ACG_ADDR_GAIN_LO, `ACG_ADDR_GAIN_HI, `ACG_ADDR_GPIO_LD, `ACG_ADDR_GPIO_FS};
    logic [7:0]  rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0]  wr_tab [5] = '{8'hA5, 8'h3C, 8'h00, 8'h5A, 8'hC3};

    acg_spi_if link ();

    // pins take the device's level where its drive enable is set, the external level elsewhere
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_ext);

    acg_host i_acg_host (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
        .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .link(link.host));
    // six-channel build so the disabled-until-selected read path is exercised
    acg_dev #(.SIX_CHAN(1'b1)) i_acg_dev (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .link(link.dev),
        .offset_cal_value_out(ofs_val), .gain_cal_value_out(gain_val), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_out(gpio_oe));
    acg_link_check i_acg_link_check (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .serial_out_ready_pin(link.serial_out_ready_pin));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one classic cycle; entered just after a rising edge
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        wb_sel <= 4'hF;
        do begin
            @(posedge sys_clk_in);
            n++;
            if (n > 20) begin
                err_total++;
                report_and_stop();
            end
        end while (wb_ack !== 1'b1);
        wb_rdat_q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    // start is an argument; every call here sets it, the refused second start included
    task automatic dev_access(input logic st, input logic we, input logic [4:0] a,
                              input logic [7:0] d);
        int n;
        n = 0;
        wb_cycle(1'b1, `ACG_WB_CTRL, {8'h00, d, 3'h0, a, 6'h00, we, st});
        do begin
            wb_cycle(1'b0, `ACG_WB_STAT, 32'h0000_0000);
            n++;
            if (n > 400) begin
                err_total++;
                report_and_stop();
            end
        end while (wb_rdat_q[1] !== 1'b1);
        rd_byte = wb_rdat_q[15:8];
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        samples_checked = 0;
        reset_n_in = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_sel = 4'h0;
        wb_wdat = 32'h0000_0000;
        pin_ext = 4'hA;
        repeat (6) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        // device sync pipes need a few edges before the first frame
        repeat (5) @(posedge sys_clk_in);
        check("offset out", {16'h0000, ofs_val}, 32'h0000_0000);
        check("gain out", {16'h0000, gain_val}, 32'h0000_4000);
        check("pin enable", {28'h0, gpio_oe}, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            dev_access(1'b1, 1'b0, addr_tab[i], 8'h00);
            check("reset value", {24'h0, rd_byte}, {24'h0, rst_tab[i]});
        end
        for (int i = 0; i < 5; i++) begin
            dev_access(1'b1, 1'b1, addr_tab[i], wr_tab[i]);
        end
        for (int i = 0; i < 5; i++) begin
            dev_access(1'b1, 1'b0, addr_tab[i], 8'h00);
            check("readback", {24'h0, rd_byte}, {24'h0, wr_tab[i]});
        end
        check("offset out", {16'h0000, ofs_val}, 32'h0000_3CA5);
        check("gain out", {16'h0000, gain_val}, 32'h0000_C35A);
        // unmapped places read zero and drop writes
        dev_access(1'b1, 1'b1, 5'h05, 8'h77);
        dev_access(1'b1, 1'b0, 5'h05, 8'h00);
        check("unmapped dev", {24'h0, rd_byte}, 32'h0000_0000);
        wb_cycle(1'b0, 4'h8, 32'h0000_0000);
        check("unmapped wb", wb_rdat_q, 32'h0000_0000);
        // a second start while busy must not replace the first order
        wb_cycle(1'b1, `ACG_WB_CTRL, {8'h00, 8'h11, 3'h0, `ACG_ADDR_GAIN_LO, 6'h00, 2'b11});
        dev_access(1'b1, 1'b1, `ACG_ADDR_GAIN_LO, 8'h77);
        dev_access(1'b1, 1'b0, `ACG_ADDR_GAIN_LO, 8'h00);
        check("busy start", {24'h0, rd_byte}, 32'h0000_0011);
        // pins 0 and 1 inputs, 2 and 3 outputs
        dev_access(1'b1, 1'b1, `ACG_ADDR_GPIO_LD, 8'h35);
        check("pin enable analog", {28'h0, gpio_oe}, 32'h0000_0000);
        dev_access(1'b1, 1'b1, `ACG_ADDR_GPIO_FS, 8'hFF);
        dev_access(1'b1, 1'b0, `ACG_ADDR_GPIO_FS, 8'h00);
        check("function read", {24'h0, rd_byte}, 32'h0000_000F);
        check("pin enable", {28'h0, gpio_oe}, 32'h0000_000C);
        check("pin out", {28'h0, gpio_out}, 32'h0000_0005);
        dev_access(1'b1, 1'b0, `ACG_ADDR_GPIO_LD, 8'h00);
        check("pin read a", {24'h0, rd_byte}, 32'h0000_0036);
        pin_ext <= 4'h5;
        dev_access(1'b1, 1'b0, `ACG_ADDR_GPIO_LD, 8'h00);
        check("pin read b", {24'h0, rd_byte}, 32'h0000_0035);
        dev_access(1'b1, 1'b1, `ACG_ADDR_GPIO_FS, 8'h00);
        check("pin enable off", {28'h0, gpio_oe}, 32'h0000_0000);
        dev_access(1'b1, 1'b0, `ACG_ADDR_GPIO_LD, 8'h00);
        check("pin read off", {24'h0, rd_byte}, 32'h0000_0030);
        report_and_stop();
    end
endmodule // adc_calibration_gpio_registers_bench
